//--- hdl/exec_unit.sv
// execution unit for rotate, bit transfer, flag, data transfer and control instructions
// Function
// - rotate right through carry, flags Z C N V
// - copy selected register bit into transfer flag
// - copy transfer flag into selected register bit
// - each status flag set or cleared alone
// - post-increment load reads then bumps pointer
// - pre-decrement load drops pointer then reads
// - offset load from y or z plus displacement
// - post-increment store writes then bumps pointer
// - pre-decrement store drops pointer then writes
// - offset store to y or z plus displacement
// - direct load from address in instruction
// - direct store to address in instruction
// - program memory byte read, three cycles
// - push register onto stack, two cycles
// - pop register from stack, two cycles
// - sleep issues in one cycle, pulses request
// - watchdog restart pulse in one cycle
// - break acts only with debugging enabled
`timescale 1ns/1ns
module exec_unit #(
    parameter logic [15:0] SP_INIT = exec_pkg::SP_RESET // stack pointer after reset
) (
    input  wire logic             clock,        // 20 MHz system clock
    input  wire logic             rst,          // asynchronous reset, active high
    input  wire exec_pkg::instr_t ins,          // decoded instruction
    input  wire logic             issue_valid,  // instruction offered
    output logic                  issue_ready,  // unit can take an instruction
    input  wire exec_pkg::bus_req_t bus,        // register port request
    output logic [7:0]            bus_rdata,    // read data, cycle after read strobe
    output logic [15:0]           dmem_addr,    // data memory address
    output logic [7:0]            dmem_wdata,   // data memory write data
    output logic                  dmem_we,      // data memory write strobe
    output logic                  dmem_re,      // data memory read strobe
    input  wire logic [7:0]       dmem_rdata,   // read data, same cycle as dmem_re
    output logic [15:0]           pmem_addr,    // program memory byte address
    output logic                  pmem_re,      // program memory read strobe
    input  wire logic [7:0]       pmem_rdata,   // read data, cycle after pmem_re
    output logic                  flash_req,    // program memory write request
    output logic [15:0]           flash_wdata,  // word to be written
    input  wire logic             flash_done,   // flash write finished
    output logic                  sleep_pulse,  // to power management
    output logic                  wdr_pulse,    // to watchdog timer
    input  wire logic             debug_en,     // on-chip debugging in use
    output logic                  break_pulse   // to debug logic
);
    typedef enum logic [2:0] {st_idle, st_mem, st_pm1, st_pm2, st_flash} state_t;

    if (SP_INIT == 16'h0000) begin : g_bad_sp
        $error("stack pointer cannot start at zero");
    end

    state_t      state_q;
    state_t      state_d;
    logic [7:0]  rf_q [32];
    logic [7:0]  sr_q;
    logic [7:0]  sr_d;
    logic [15:0] sp_q;
    logic [4:0]  dst_q;
    logic        pm_active_q;

    wire exec_pkg::op_t op = ins.op;
    wire take = issue_valid && issue_ready;
    wire [7:0] rd_v = rf_q[ins.reg_sel];

    // pointer pair selection; program memory access always uses z
    wire pm_op = op == exec_pkg::op_program_memory_read || op == exec_pkg::op_program_memory_write;
    wire [4:0] pl = pm_op ? exec_pkg::PTR_Z_LO : 5'(exec_pkg::PTR_X_LO + {2'b00, ins.ptr, 1'b0});
    wire [4:0] ph = pl + 5'h01;
    wire [15:0] ptr_v = {rf_q[ph], rf_q[pl]};
    wire [15:0] ptr_inc = ptr_v + 16'h0001;
    wire [15:0] ptr_dec = ptr_v - 16'h0001;
    wire [15:0] ptr_off = ptr_v + {10'h000, ins.disp};
    wire post = ins.mode == exec_pkg::am_post_inc;
    wire pre = ins.mode == exec_pkg::am_pre_dec;
    wire [15:0] ind_ea = pre ? ptr_dec : (ins.mode == exec_pkg::am_offset) ? ptr_off : ptr_v;
    wire [15:0] ptr_new = pre ? ptr_dec : ptr_inc;

    wire is_ind = op == exec_pkg::op_load_ind || op == exec_pkg::op_store_ind;
    wire ptr_we = take && (post || pre) && (is_ind || op == exec_pkg::op_program_memory_read);
    wire is_ld = op == exec_pkg::op_load_ind || op == exec_pkg::op_load_direct || op == exec_pkg::op_pop;
    wire is_st = op == exec_pkg::op_store_ind || op == exec_pkg::op_store_direct || op == exec_pkg::op_push;
    wire [15:0] sp_inc = sp_q + 16'h0001;
    wire [15:0] sp_dec = sp_q - 16'h0001;
    wire direct = op == exec_pkg::op_load_direct || op == exec_pkg::op_store_direct;
    wire [15:0] ea = direct ? ins.addr
                   : (op == exec_pkg::op_push) ? sp_q
                   : (op == exec_pkg::op_pop) ? sp_inc : ind_ea;

    // single-cycle register results
    wire [7:0] ror_res = {sr_q[exec_pkg::SR_C], rd_v[7:1]};
    wire [7:0] bit_mask = 8'h01 << ins.bit_sel;
    wire [7:0] bld_res = (rd_v & ~bit_mask) | (sr_q[exec_pkg::SR_T] ? bit_mask : 8'h00);
    wire is_ror = op == exec_pkg::op_rotate_right_carry;
    wire exec_we = take && (is_ror || op == exec_pkg::op_transfer_flag_to_bit);
    wire [7:0] exec_res = is_ror ? ror_res : bld_res;

    // late write of loaded data at the end of the access
    wire late_we = (state_q == st_mem && dmem_re) || pm_active_q;
    wire [7:0] late_data = pm_active_q ? pmem_rdata : dmem_rdata;

    wire bus_rf = bus.we && bus.addr <= exec_pkg::REG_FILE_TOP;
    wire bus_sr = bus.we && bus.addr == exec_pkg::STATUS_OFF;
    wire [7:0] rd_mux = (bus.addr <= exec_pkg::REG_FILE_TOP) ? rf_q[bus.addr[4:0]]
                      : (bus.addr == exec_pkg::SP_LO_OFF) ? sp_q[7:0]
                      : (bus.addr == exec_pkg::SP_HI_OFF) ? sp_q[15:8]
                      : (bus.addr == exec_pkg::STATUS_OFF) ? sr_q : 8'h00;

    assign issue_ready = state_q == st_idle;

    always_comb begin
        sr_d = sr_q;
        if (bus_sr) begin
            sr_d = bus.wdata;
        end
        if (take) begin
            case (op)
                exec_pkg::op_rotate_right_carry: begin
                    sr_d[exec_pkg::SR_C] = rd_v[0];
                    sr_d[exec_pkg::SR_N] = ror_res[7];
                    sr_d[exec_pkg::SR_Z] = ror_res == 8'h00;
                    sr_d[exec_pkg::SR_V] = ror_res[7] ^ rd_v[0];
                end
                exec_pkg::op_bit_to_transfer_flag: sr_d[exec_pkg::SR_T] = rd_v[ins.bit_sel];
                exec_pkg::op_flag_set: sr_d[ins.bit_sel] = 1'b1;
                exec_pkg::op_flag_clear: sr_d[ins.bit_sel] = 1'b0;
                default: ;
            endcase
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            st_idle: begin
                if (take && (is_ld || is_st)) begin
                    state_d = st_mem;
                end else if (take && op == exec_pkg::op_program_memory_read) begin
                    state_d = st_pm1;
                end else if (take && op == exec_pkg::op_program_memory_write) begin
                    state_d = st_flash;
                end
            end
            st_mem: state_d = st_idle;
            st_pm1: state_d = st_pm2;
            st_pm2: state_d = st_idle;
            st_flash: state_d = flash_done ? st_idle : st_flash;
            default: state_d = st_idle;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= st_idle;
            sr_q    <= exec_pkg::STATUS_RESET;
        end else begin
            state_q <= state_d;
            sr_q    <= sr_d;
        end
    end

    // register file: bus first, execution results take precedence
    always_ff @(posedge clock) begin
        if (bus_rf) begin
            rf_q[bus.addr[4:0]] <= bus.wdata;
        end
        if (exec_we) begin
            rf_q[ins.reg_sel] <= exec_res;
        end
        if (ptr_we) begin
            {rf_q[ph], rf_q[pl]} <= ptr_new;
        end
        if (late_we) begin
            rf_q[dst_q] <= late_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sp_q <= SP_INIT;
        end else if (take && op == exec_pkg::op_push) begin
            sp_q <= sp_dec;
        end else if (take && op == exec_pkg::op_pop) begin
            sp_q <= sp_inc;
        end else if (bus.we && bus.addr == exec_pkg::SP_LO_OFF) begin
            sp_q[7:0] <= bus.wdata;
        end else if (bus.we && bus.addr == exec_pkg::SP_HI_OFF) begin
            sp_q[15:8] <= bus.wdata;
        end
    end

    // memory strobes stand for the one access cycle after the take
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dmem_addr  <= 16'h0000;
            dmem_wdata <= 8'h00;
            dmem_we    <= 1'b0;
            dmem_re    <= 1'b0;
            dst_q      <= 5'h00;
        end else begin
            dmem_we <= take && is_st;
            dmem_re <= take && is_ld;
            if (take) begin
                dmem_addr  <= ea;
                dmem_wdata <= rd_v;
                dst_q      <= ins.reg_sel;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pmem_addr   <= 16'h0000;
            pmem_re     <= 1'b0;
            pm_active_q <= 1'b0;
            flash_req   <= 1'b0;
            flash_wdata <= 16'h0000;
        end else begin
            pmem_re <= take && op == exec_pkg::op_program_memory_read;
            pm_active_q <= pmem_re;
            if (take && pm_op) begin
                pmem_addr   <= ptr_v;
                flash_wdata <= {rf_q[1], rf_q[0]};
            end
            if (take && op == exec_pkg::op_program_memory_write) begin
                flash_req <= 1'b1;
            end else if (flash_done) begin
                flash_req <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sleep_pulse <= 1'b0;
            wdr_pulse   <= 1'b0;
            break_pulse <= 1'b0;
            bus_rdata   <= 8'h00;
        end else begin
            sleep_pulse <= take && op == exec_pkg::op_sleep;
            wdr_pulse   <= take && op == exec_pkg::op_watchdog_restart;
            break_pulse <= take && op == exec_pkg::op_break && debug_en;
            bus_rdata   <= bus.re ? rd_mux : 8'h00;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_ror_result: assert property (
        take && is_ror && !bus.we |=> rf_q[$past(ins.reg_sel)] == $past(ror_res)
            && sr_q[exec_pkg::SR_C] == $past(rd_v[0]) && sr_q[exec_pkg::SR_S] == $past(sr_q[exec_pkg::SR_S]))
        else $error("rotate result or carry wrong");

    a_bit_to_flag: assert property (
        take && op == exec_pkg::op_bit_to_transfer_flag && !bus.we
            |=> sr_q[exec_pkg::SR_T] == $past(rd_v[ins.bit_sel]) && sr_q[5:0] == $past(sr_q[5:0])
            && sr_q[exec_pkg::SR_I] == $past(sr_q[exec_pkg::SR_I]))
        else $error("transfer flag not loaded from bit");

    a_flag_to_bit: assert property (
        take && op == exec_pkg::op_transfer_flag_to_bit && !bus.we
            |=> rf_q[$past(ins.reg_sel)] == $past(bld_res) && sr_q == $past(sr_q))
        else $error("register bit not loaded from transfer flag");

    a_flag_single: assert property (
        take && op == exec_pkg::op_flag_set && !bus.we |=> sr_q == ($past(sr_q) | $past(bit_mask)))
        else $error("flag set touched other flags");

    a_flag_clear: assert property (
        take && op == exec_pkg::op_flag_clear && !bus.we |=> sr_q == ($past(sr_q) & ~$past(bit_mask)))
        else $error("flag clear touched other flags");

    a_post_inc_ptr: assert property (
        take && is_ind && post && !bus.we
            |=> dmem_addr == $past(ptr_v) && {rf_q[$past(ph)], rf_q[$past(pl)]} == dmem_addr + 16'h0001)
        else $error("post-increment address or pointer wrong");

    a_pre_dec_ptr: assert property (
        take && is_ind && pre && !bus.we
            |=> dmem_addr == $past(ptr_v) - 16'h0001 && {rf_q[$past(ph)], rf_q[$past(pl)]} == dmem_addr)
        else $error("pre-decrement address or pointer wrong");

    a_offset_addr: assert property (
        take && is_ind && ins.mode == exec_pkg::am_offset && !bus.we
            |=> dmem_addr == $past(ptr_off) && {rf_q[$past(ph)], rf_q[$past(pl)]} == $past(ptr_v))
        else $error("offset access moved pointer or wrong address");

    a_load_two_cyc: assert property (
        take && is_ld |=> dmem_re && !issue_ready ##1 issue_ready && !dmem_re)
        else $error("load did not take two cycles");

    a_store_two_cyc: assert property (
        take && is_st |=> dmem_we && !dmem_re && !issue_ready ##1 issue_ready && !dmem_we)
        else $error("store did not take two cycles");

    a_direct_store: assert property (
        take && op == exec_pkg::op_store_direct
            |=> dmem_we && dmem_addr == $past(ins.addr) && dmem_wdata == $past(rd_v) ##1 issue_ready)
        else $error("direct store wrong");

    a_prog_read: assert property (
        take && op == exec_pkg::op_program_memory_read
            |=> pmem_re && pmem_addr == $past(ptr_v) ##1 !issue_ready ##1 issue_ready)
        else $error("program memory read not three cycles");

    a_push_stack: assert property (
        take && op == exec_pkg::op_push && !bus.we
            |=> dmem_we && dmem_addr == $past(sp_q) && sp_q == $past(sp_dec) && sr_q == $past(sr_q))
        else $error("push wrong");

    a_pop_stack: assert property (
        take && op == exec_pkg::op_pop && !bus.we
            |=> dmem_re && dmem_addr == $past(sp_inc) && sp_q == $past(sp_inc) && sr_q == $past(sr_q))
        else $error("pop wrong");

    a_ctrl_pulse: assert property (
        take && (op == exec_pkg::op_sleep || op == exec_pkg::op_watchdog_restart)
            |=> (sleep_pulse || wdr_pulse) && issue_ready ##1 !sleep_pulse && !wdr_pulse)
        else $error("control pulse wrong");

    a_wdr_flags: assert property (
        take && op == exec_pkg::op_watchdog_restart && !bus.we
            |=> wdr_pulse && !sleep_pulse && sr_q == $past(sr_q))
        else $error("watchdog restart wrong");

    a_break_gated: assert property (
        break_pulse |-> $past(debug_en))
        else $error("break without debugging");

    a_break_taken: assert property (
        take && op == exec_pkg::op_break && debug_en |=> break_pulse)
        else $error("break with debugging gave no pulse");

    a_flash_stall: assert property (
        flash_req && !flash_done |=> !issue_ready)
        else $error("issued during program memory write");

    a_flash_end: assert property (
        flash_req && flash_done |=> !flash_req && issue_ready)
        else $error("program memory write did not end on done");

    c_pop: cover property (take && op == exec_pkg::op_pop ##2 take);
    c_prog_read: cover property (take && op == exec_pkg::op_program_memory_read ##3 take);
    c_flash: cover property (flash_req ##3 flash_done);
    c_break: cover property (break_pulse);
    c_offset_store: cover property (take && is_st && ins.mode == exec_pkg::am_offset);
endmodule : exec_unit

//--- hdl/exec_pkg.sv
// shared types and constants for the bit, transfer and control execution unit
package exec_pkg;
    typedef enum logic [4:0] {
        op_nop, op_rotate_right_carry, op_bit_to_transfer_flag, op_transfer_flag_to_bit,
        op_flag_set, op_flag_clear, op_load_ind, op_store_ind, op_load_direct,
        op_store_direct, op_program_memory_read, op_program_memory_write,
        op_push, op_pop, op_sleep, op_watchdog_restart, op_break
    } op_t;

    typedef enum logic [1:0] {am_plain, am_post_inc, am_pre_dec, am_offset} addr_mode_t;

    typedef struct packed {
        op_t        op;
        addr_mode_t mode;
        logic [1:0] ptr;    // 0 x, 1 y, 2 z
        logic [4:0] reg_sel; // destination or source register
        logic [2:0] bit_sel; // register bit or status flag index
        logic [5:0] disp;
        logic [15:0] addr;
    } instr_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } bus_req_t;

    localparam int SR_C = 0;
    localparam int SR_Z = 1;
    localparam int SR_N = 2;
    localparam int SR_V = 3;
    localparam int SR_S = 4;
    localparam int SR_H = 5;
    localparam int SR_T = 6;
    localparam int SR_I = 7;

    localparam logic [5:0]  REG_FILE_TOP = 6'h1f;
    localparam logic [5:0]  SP_LO_OFF    = 6'h3d;
    localparam logic [5:0]  SP_HI_OFF    = 6'h3e;
    localparam logic [5:0]  STATUS_OFF   = 6'h3f;
    localparam logic [7:0]  STATUS_RESET = 8'h00;
    localparam logic [15:0] SP_RESET     = 16'h00ff;
    localparam logic [4:0]  PTR_X_LO     = 5'h1a;
    localparam logic [4:0]  PTR_Z_LO     = 5'h1e;
endpackage : exec_pkg

//--- sim/mem_model.sv
// data memory, program memory and flash write model facing the execution unit
`timescale 1ns/1ns
module mem_model #(
    parameter int FLASH_WAIT = 5 // cycles a flash write takes
) (
    input  wire logic        clock,       // system clock
    input  wire logic [15:0] dmem_addr,   // data address
    input  wire logic [7:0]  dmem_wdata,  // data to store
    input  wire logic        dmem_we,     // store strobe
    input  wire logic        dmem_re,     // load strobe
    output logic [7:0]       dmem_rdata,  // load data, same cycle
    input  wire logic [15:0] pmem_addr,   // program byte address
    input  wire logic        pmem_re,     // program read strobe
    output logic [7:0]       pmem_rdata,  // program data, next cycle
    input  wire logic        flash_req,   // flash write request
    input  wire logic [15:0] flash_wdata, // word to write
    output logic             flash_done   // flash write finished
);
    logic [7:0]  dmem [0:511];
    logic [15:0] flash_word;
    int          wait_cnt;
    initial begin
        for (int i = 0; i < 512; i++) begin
            dmem[i] = 8'(i) ^ {i[8], 7'h25};
        end
        pmem_rdata = 8'h00;
        flash_word = 16'h0000;
        wait_cnt = 0;
    end
    // unselected data bus shows the inverse, never a stale byte
    assign dmem_rdata = dmem_re ? dmem[dmem_addr[8:0]] : ~dmem[dmem_addr[8:0]];
    assign flash_done = flash_req && (wait_cnt == FLASH_WAIT);
    always @(posedge clock) begin
        if (dmem_we) begin
            dmem[dmem_addr[8:0]] <= dmem_wdata;
        end
        pmem_rdata <= pmem_re ? (pmem_addr[7:0] ^ 8'h3c) : ~pmem_rdata;
        wait_cnt <= (flash_req && !flash_done) ? wait_cnt + 1 : 0;
        if (flash_req && flash_done) begin
            flash_word <= flash_wdata;
        end
    end
endmodule : mem_model

//--- sim/tb_mcu_bitop_transfer_control_exec.sv
// self-checking bench for the bit, transfer and control execution unit
`timescale 1ns/1ns
module tb_mcu_bitop_transfer_control_exec;
    localparam logic [5:0] ST = exec_pkg::STATUS_OFF;
    logic clock, rst, issue_valid, issue_ready, dmem_we, dmem_re, pmem_re;
    logic flash_req, flash_done, sleep_pulse, wdr_pulse, debug_en, break_pulse;
    exec_pkg::instr_t   ins;
    exec_pkg::bus_req_t bus;
    logic [7:0]  bus_rdata, dmem_wdata, dmem_rdata, pmem_rdata, ev;
    logic [15:0] dmem_addr, pmem_addr, flash_wdata, base;
    logic [5:0]  lo;
    int mismatches = 0, compares = 0, n_sleep = 0, n_wdr = 0, n_brk = 0, busy;
    exec_unit u_dut (.clock(clock), .rst(rst), .ins(ins), .issue_valid(issue_valid),
        .issue_ready(issue_ready), .bus(bus), .bus_rdata(bus_rdata), .dmem_addr(dmem_addr),
        .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re), .dmem_rdata(dmem_rdata),
        .pmem_addr(pmem_addr), .pmem_re(pmem_re), .pmem_rdata(pmem_rdata), .flash_req(flash_req),
        .flash_wdata(flash_wdata), .flash_done(flash_done), .sleep_pulse(sleep_pulse),
        .wdr_pulse(wdr_pulse), .debug_en(debug_en), .break_pulse(break_pulse));
    mem_model u_mem (.clock(clock), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we),
        .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr), .pmem_re(pmem_re),
        .pmem_rdata(pmem_rdata), .flash_req(flash_req), .flash_wdata(flash_wdata),
        .flash_done(flash_done));
    initial clock = 1'b0;
    always #25 clock = ~clock;
    always @(posedge clock) begin
        n_sleep += (sleep_pulse === 1'b1);
        n_wdr += (wdr_pulse === 1'b1);
        n_brk += (break_pulse === 1'b1);
    end
    task automatic final_report;
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask : wr
    task automatic rd(input string what, input logic [5:0] a, input logic [7:0] exp);
        @(posedge clock);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus <= '0;
        #1;
        chk(what, {8'h00, exp}, {8'h00, bus_rdata});
    endtask : rd
    task automatic run(input exec_pkg::op_t o, input exec_pkg::addr_mode_t m, input logic [1:0] p,
                       input logic [4:0] r, input logic [2:0] b, input logic [5:0] dp,
                       input logic [15:0] a, input int eb);
        @(posedge clock);
        ins <= '{o, m, p, r, b, dp, a};
        issue_valid <= 1'b1;
        @(posedge clock);
        issue_valid <= 1'b0;
        busy = 0;
        #1;
        while (issue_ready !== 1'b1 && busy < 200) begin
            @(posedge clock);
            #1;
            busy++;
        end
        if (busy >= 200) begin
            mismatches++;
            final_report();
        end else if (eb >= 0) begin
            chk("busy cycles", 16'(eb), 16'(busy));
        end
    endtask : run
    task automatic op(input exec_pkg::op_t o, input logic [4:0] r, input logic [2:0] b, input int eb);
        run(o, exec_pkg::am_plain, 2'd0, r, b, 6'h00, 16'h0000, eb);
    endtask : op
    task automatic ptr(input logic [5:0] a, input logic [15:0] v);
        rd("pointer low", a, v[7:0]);
        rd("pointer high", a + 6'h01, v[15:8]);
    endtask : ptr
    task automatic rot(input logic [5:0] r, input logic [7:0] v, input logic [7:0] s);
        op(exec_pkg::op_rotate_right_carry, r[4:0], 3'd0, 0);
        rd("rotate value", r, v);
        rd("rotate flags", ST, s);
    endtask : rot
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        final_report();
    end
    initial begin
        ins = '0;
        issue_valid = 1'b0;
        bus = '0;
        debug_en = 1'b0;
        rst = 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd("status reset", ST, exec_pkg::STATUS_RESET);
        rd("sp low reset", exec_pkg::SP_LO_OFF, exec_pkg::SP_RESET[7:0]);
        rd("sp high reset", exec_pkg::SP_HI_OFF, exec_pkg::SP_RESET[15:8]);
        wr(6'h25, 8'h99);
        rd("unmapped", 6'h25, 8'h00);
        wr(ST, 8'h00);
        ev = 8'h00;
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 8; k++) begin
                op(s ? exec_pkg::op_flag_clear : exec_pkg::op_flag_set, 5'd0, k[2:0], 0);
                ev[k] = (s == 0);
                rd("single flag", ST, ev);
            end
        end
        wr(ST, 8'h70);
        wr(6'h05, 8'h81);
        wr(6'h06, 8'h01);
        rot(6'h05, 8'h40, 8'h79);
        rot(6'h05, 8'ha0, 8'h7c);
        rot(6'h06, 8'h00, 8'h7b);
        wr(6'h07, 8'h20);
        wr(6'h08, 8'h00);
        wr(ST, 8'hbf);
        op(exec_pkg::op_bit_to_transfer_flag, 5'd7, 3'd5, 0);
        rd("transfer flag set", ST, 8'hff);
        op(exec_pkg::op_transfer_flag_to_bit, 5'd8, 3'd3, 0);
        rd("bit loaded", 6'h08, 8'h08);
        rd("flags after bit load", ST, 8'hff);
        op(exec_pkg::op_bit_to_transfer_flag, 5'd7, 3'd0, 0);
        rd("transfer flag clear", ST, 8'hbf);
        op(exec_pkg::op_transfer_flag_to_bit, 5'd8, 3'd3, 0);
        rd("bit cleared", 6'h08, 8'h00);
        for (int p = 0; p < 3; p++) begin
            lo = {1'b0, exec_pkg::PTR_X_LO} + 6'(2 * p);
            base = (p == 2) ? 16'h00ff : 16'h0030 + 16'(16 * p);
            wr(lo, base[7:0]);
            wr(lo + 6'h01, base[15:8]);
            run(exec_pkg::op_load_ind, exec_pkg::am_post_inc, p[1:0], 5'd1, 3'd0, 6'h00, 16'h0, 1);
            rd("post inc load", 6'h01, u_mem.dmem[base[8:0]]);
            ptr(lo, base + 16'h1);
            run(exec_pkg::op_load_ind, exec_pkg::am_pre_dec, p[1:0], 5'd2, 3'd0, 6'h00, 16'h0, 1);
            rd("pre dec load", 6'h02, u_mem.dmem[base[8:0]]);
            ptr(lo, base);
            wr(6'h03, 8'h60 + 8'(p));
            wr(6'h04, 8'h70 + 8'(p));
            run(exec_pkg::op_store_ind, exec_pkg::am_post_inc, p[1:0], 5'd3, 3'd0, 6'h00, 16'h0, 1);
            chk("post inc store", 16'h60 + 16'(p), {8'h00, u_mem.dmem[base[8:0]]});
            ptr(lo, base + 16'h1);
            run(exec_pkg::op_store_ind, exec_pkg::am_pre_dec, p[1:0], 5'd4, 3'd0, 6'h00, 16'h0, 1);
            chk("pre dec store", 16'h70 + 16'(p), {8'h00, u_mem.dmem[base[8:0]]});
            ptr(lo, base);
            if (p > 0) begin
                run(exec_pkg::op_load_ind, exec_pkg::am_offset, p[1:0], 5'd1, 3'd0, 6'h3f, 16'h0, 1);
                rd("offset load", 6'h01, u_mem.dmem[9'(base + 16'h3f)]);
                run(exec_pkg::op_store_ind, exec_pkg::am_offset, p[1:0], 5'd3, 3'd0, 6'h01, 16'h0, 1);
                chk("offset store", 16'h60 + 16'(p), {8'h00, u_mem.dmem[9'(base + 16'h1)]});
                ptr(lo, base);
            end
        end
        run(exec_pkg::op_load_direct, exec_pkg::am_plain, 2'd0, 5'd9, 3'd0, 6'h00, 16'h0155, 1);
        rd("direct load", 6'h09, u_mem.dmem[9'h155]);
        run(exec_pkg::op_store_direct, exec_pkg::am_plain, 2'd0, 5'd9, 3'd0, 6'h00, 16'h0066, 1);
        chk("direct store", {8'h00, u_mem.dmem[9'h155]}, {8'h00, u_mem.dmem[9'h066]});
        wr(ST, 8'h55);
        wr(6'h0a, 8'h3e);
        op(exec_pkg::op_push, 5'd10, 3'd0, 1);
        chk("push data", 16'h003e, {8'h00, u_mem.dmem[9'h0ff]});
        rd("sp after push", exec_pkg::SP_LO_OFF, 8'hfe);
        op(exec_pkg::op_pop, 5'd11, 3'd0, 1);
        rd("pop data", 6'h0b, 8'h3e);
        rd("sp after pop", exec_pkg::SP_LO_OFF, 8'hff);
        rd("flags after stack", ST, 8'h55);
        wr(6'h1e, 8'h42);
        wr(6'h1f, 8'h00);
        op(exec_pkg::op_program_memory_read, 5'd0, 3'd0, 2);
        rd("program read r0", 6'h00, 8'h7e);
        run(exec_pkg::op_program_memory_read, exec_pkg::am_post_inc, 2'd2, 5'd12, 3'd0, 6'h00, 16'h0, 2);
        rd("program read reg", 6'h0c, 8'h7e);
        ptr(6'h1e, 16'h0043);
        wr(6'h00, 8'h11);
        wr(6'h01, 8'h22);
        op(exec_pkg::op_program_memory_write, 5'd0, 3'd0, -1);
        chk("flash word", 16'h2211, u_mem.flash_word);
        chk("flash stall", 16'h1, 16'(busy >= 5));
        chk("flash request", 16'h0, {15'h0, flash_req});
        op(exec_pkg::op_sleep, 5'd0, 3'd0, 0);
        op(exec_pkg::op_watchdog_restart, 5'd0, 3'd0, 0);
        op(exec_pkg::op_break, 5'd0, 3'd0, -1);
        chk("break without debug", 16'h0, {15'h0, break_pulse});
        debug_en <= 1'b1;
        op(exec_pkg::op_break, 5'd0, 3'd0, -1);
        repeat (2) @(posedge clock);
        chk("sleep pulses", 16'h1, 16'(n_sleep));
        chk("restart pulses", 16'h1, 16'(n_wdr));
        chk("break pulses", 16'h1, 16'(n_brk));
        rd("flags after control", ST, 8'h55);
        final_report();
    end
endmodule : tb_mcu_bitop_transfer_control_exec
